// ---- common/bfi_defines.svh ----
// Constants for the breaker-failure initiation block: widths, counts and timing.
// Assumes a 40 MHz system clock and per-unit current magnitudes in thousandths.
`ifndef BFI_DEFINES_SVH
`define BFI_DEFINES_SVH

`define BFI_NUM_INST      2
`define BFI_NUM_GROUPS    6
`define BFI_NUM_SRC       4
`define BFI_LEVEL_W       15
`define BFI_DELAY_W       16
`define BFI_DELAY_MAX     16'hFFFF
`define BFI_DELAY_ONE     16'h0001
`define BFI_LOSET_DELAY   16'h0010
`define BFI_GROUP_NONE    3'h0
`define BFI_GROUP_FIRST   3'h1
`define BFI_GROUP_LAST    3'h6
`define BFI_GROUP_DEFAULT 3'h0
`define BFI_TICK_NS       1000000
`define BFI_MCLK_NS       25
`define BFI_DIV_W         16
`define BFI_DIV_ONE       16'h0001

`endif

// ---- common/bfi_pkg.sv ----
// Types and small helpers shared by the breaker-failure initiation modules.
// Assumes bfi_defines.svh is on the include path.
`default_nettype none
`include "bfi_defines.svh"

package bfi_pkg;

    typedef logic [`BFI_LEVEL_W-1:0] bfi_level_t;
    typedef logic [`BFI_DELAY_W-1:0] bfi_delay_t;

    typedef enum logic {
        three_phase_scheme,
        single_phase_scheme
    } bfi_pole_t;

    // Settings of one instance as taken from the active group.
    typedef struct packed {
        logic       enable;
        bfi_pole_t  pole_mode;
        logic [1:0] measurement_source;
        logic       current_supervised_initiate_en;
        logic       hold_initiation_en;
        bfi_level_t phase_supervision_level;
        bfi_level_t neutral_supervision_level;
        logic       early_path_en;
        logic       main_path_en;
        logic       slow_path_en;
        bfi_delay_t early_path_delay;
        bfi_delay_t main_path_delay;
        bfi_delay_t slow_path_delay;
        bfi_level_t phase_high_level;
        bfi_level_t neutral_high_level;
        bfi_level_t phase_low_level;
    } bfi_settings_t;

    // State of one element instance.
    typedef struct packed {
        logic       hold;
        bfi_delay_t t_early;
        bfi_delay_t t_main;
        bfi_delay_t t_slow;
        bfi_delay_t t_loset;
        logic       retrip;
        logic       early_fail;
        logic       main_fail;
        logic       slow_fail;
        logic       zone_trip;
    } bfi_inst_t;

    // Whole state of the top module.
    typedef struct packed {
        logic [`BFI_DIV_W-1:0]        div;
        logic                         tick;
        bfi_inst_t [`BFI_NUM_INST-1:0] inst;
    } bfi_state_t;

    // True when any phase magnitude reaches the level.
    function automatic logic bfi_any_ge(input bfi_level_t [2:0] ph, input bfi_level_t lvl);
        bfi_any_ge = (ph[0] >= lvl) || (ph[1] >= lvl) || (ph[2] >= lvl);
    endfunction

    // Saturating millisecond counter step.
    function automatic bfi_delay_t bfi_bump(input bfi_delay_t cnt, input logic en);
        bfi_bump = (en && cnt != `BFI_DELAY_MAX) ? bfi_delay_t'(cnt + `BFI_DELAY_ONE) : cnt;
    endfunction

endpackage

`default_nettype wire

// ---- rtl/bfi_group_select.sv ----
// Picks one instance's settings out of the six setting groups.
// Assumes the active group number arrives from same-clock control logic.
`default_nettype none
`include "bfi_defines.svh"

module bfi_group_select (
    input  wire logic [2:0]                       active_group,
    input  wire logic [5:0]                       enable_g,
    input  wire bfi_pkg::bfi_pole_t [5:0]         pole_mode_g,
    input  wire logic [5:0][1:0]                  measurement_source_g,
    input  wire logic [5:0]                       supv_init_g,
    input  wire logic [5:0]                       hold_en_g,
    input  wire bfi_pkg::bfi_level_t [5:0]        ph_supv_g,
    input  wire bfi_pkg::bfi_level_t [5:0]        n_supv_g,
    input  wire logic [5:0]                       early_en_g,
    input  wire logic [5:0]                       main_en_g,
    input  wire logic [5:0]                       slow_en_g,
    input  wire bfi_pkg::bfi_delay_t [5:0]        early_delay_g,
    input  wire bfi_pkg::bfi_delay_t [5:0]        main_delay_g,
    input  wire bfi_pkg::bfi_delay_t [5:0]        slow_delay_g,
    input  wire bfi_pkg::bfi_level_t [5:0]        ph_high_g,
    input  wire bfi_pkg::bfi_level_t [5:0]        n_high_g,
    input  wire bfi_pkg::bfi_level_t [5:0]        ph_low_g,
    output bfi_pkg::bfi_settings_t                sel
);
    import bfi_pkg::*;

    // Any group number outside one to six falls back to the first group.
    function automatic logic [2:0] bfi_group_index(input logic [2:0] g);
        if (g >= `BFI_GROUP_FIRST && g <= `BFI_GROUP_LAST) begin
            bfi_group_index = 3'(g - `BFI_GROUP_FIRST);
        end else begin
            bfi_group_index = `BFI_GROUP_DEFAULT;
        end
    endfunction

    logic [2:0] idx;

    // Every field follows the group that is active right now.
    assign idx                                = bfi_group_index(active_group);
    assign sel.enable                         = enable_g[idx];
    assign sel.pole_mode                      = pole_mode_g[idx];
    assign sel.measurement_source             = measurement_source_g[idx];
    assign sel.current_supervised_initiate_en = supv_init_g[idx];
    assign sel.hold_initiation_en             = hold_en_g[idx];
    assign sel.phase_supervision_level        = ph_supv_g[idx];
    assign sel.neutral_supervision_level      = n_supv_g[idx];
    assign sel.early_path_en                  = early_en_g[idx];
    assign sel.main_path_en                   = main_en_g[idx];
    assign sel.slow_path_en                   = slow_en_g[idx];
    assign sel.early_path_delay               = early_delay_g[idx];
    assign sel.main_path_delay                = main_delay_g[idx];
    assign sel.slow_path_delay                = slow_delay_g[idx];
    assign sel.phase_high_level               = ph_high_g[idx];
    assign sel.neutral_high_level             = n_high_g[idx];
    assign sel.phase_low_level                = ph_low_g[idx];

endmodule

`default_nettype wire

// ---- rtl/bfi_top.sv ----
// Two breaker-failure elements: initiation, seal-in, three delayed failure paths.
// Assumes operands and current magnitudes come from logic on mclk, already settled.
//
// Functional notes
// - Two identical, independent elements, each with own settings and state.
// - Each element runs three-pole only or three-pole plus single-pole, same logic.
// - Each element takes currents from one of four selectable sources.
// - All current levels span 0.001 to 30.000 pu in 0.001 steps, default 1.050.
// - Three timers, each enableable, delay zero to 65.535 s in 1 ms steps.
// - Operation runs initiation, then failure determination, then output.
// - Optional seal-in holds initiation while current stays above supervision level.
// - Initiation is either direct or current supervised.
// - Current-supervised initiation is refused when current is below supervision level.
// - Settings exist in six groups; the active group governs behaviour.
// - Group one is default and active whenever no other group is.
// - Neutral hi-set level is a setting separate from phase hi-set.
// - Initiation immediately re-trips the breaker first signalled to trip.
// - Early path fails after delay if breaker still closed and fault current present.
// - Main path fails after delay on fault current, no auxiliary contact used.
// - Slow path uses aux contact and service switch, no current check.
`default_nettype none
`include "bfi_defines.svh"

module bfi_top #(
    parameter int TICK_CYCLES = `BFI_TICK_NS / `BFI_MCLK_NS
) (
    input  wire logic                                 mclk,
    input  wire logic                                 rst,
    input  wire logic [2:0]                           active_group,
    input  wire logic [1:0][5:0]                      element_enable,
    input  wire bfi_pkg::bfi_pole_t [1:0][5:0]        pole_mode,
    input  wire logic [1:0][5:0][1:0]                 measurement_source,
    input  wire logic [1:0][5:0]                      current_supervised_initiate_en,
    input  wire logic [1:0][5:0]                      hold_initiation_en,
    input  wire bfi_pkg::bfi_level_t [1:0][5:0]       phase_supervision_level,
    input  wire bfi_pkg::bfi_level_t [1:0][5:0]       neutral_supervision_level,
    input  wire logic [1:0][5:0]                      early_path_en,
    input  wire logic [1:0][5:0]                      main_path_en,
    input  wire logic [1:0][5:0]                      slow_path_en,
    input  wire bfi_pkg::bfi_delay_t [1:0][5:0]       early_path_delay,
    input  wire bfi_pkg::bfi_delay_t [1:0][5:0]       main_path_delay,
    input  wire bfi_pkg::bfi_delay_t [1:0][5:0]       slow_path_delay,
    input  wire bfi_pkg::bfi_level_t [1:0][5:0]       phase_high_level,
    input  wire bfi_pkg::bfi_level_t [1:0][5:0]       neutral_high_level,
    input  wire bfi_pkg::bfi_level_t [1:0][5:0]       phase_low_level,
    input  wire bfi_pkg::bfi_level_t [3:0][2:0]       phase_current,
    input  wire bfi_pkg::bfi_level_t [3:0]            neutral_current,
    input  wire logic [1:0]                           three_phase_initiate,
    input  wire logic [1:0][2:0]                      phase_initiate,
    input  wire logic [1:0]                           scheme_inhibit,
    input  wire logic [1:0]                           aux_contact_early,
    input  wire logic [1:0]                           aux_contact_second,
    input  wire logic [1:0]                           out_of_service_flag,
    output logic [1:0]                                retrip,
    output logic [1:0]                                early_path_fail,
    output logic [1:0]                                main_path_fail,
    output logic [1:0]                                slow_path_fail,
    output logic [1:0]                                zone_trip
);
    import bfi_pkg::*;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    bfi_state_t      s;
    bfi_state_t      next_s;
    bfi_settings_t   cfg [`BFI_NUM_INST];
    bfi_level_t [2:0] src_ph [`BFI_NUM_INST];
    bfi_level_t      src_n [`BFI_NUM_INST];
    logic            three_pole [`BFI_NUM_INST];
    logic            blocked [`BFI_NUM_INST];
    logic            trip_op [`BFI_NUM_INST];
    logic            cur_sup [`BFI_NUM_INST];
    logic            init_ok [`BFI_NUM_INST];
    logic            active [`BFI_NUM_INST];
    logic            done_early [`BFI_NUM_INST];
    logic            done_main [`BFI_NUM_INST];
    logic            done_slow [`BFI_NUM_INST];
    logic            lo_run [`BFI_NUM_INST];
    logic            fault_cur [`BFI_NUM_INST];

    // Each element owns its group selector, current view and stage logic.
    for (genvar i = 0; i < `BFI_NUM_INST; i++) begin : g_inst
        bfi_group_select u_sel (
            .active_group         (active_group),
            .enable_g             (element_enable[i]),
            .pole_mode_g          (pole_mode[i]),
            .measurement_source_g (measurement_source[i]),
            .supv_init_g          (current_supervised_initiate_en[i]),
            .hold_en_g            (hold_initiation_en[i]),
            .ph_supv_g            (phase_supervision_level[i]),
            .n_supv_g             (neutral_supervision_level[i]),
            .early_en_g           (early_path_en[i]),
            .main_en_g            (main_path_en[i]),
            .slow_en_g            (slow_path_en[i]),
            .early_delay_g        (early_path_delay[i]),
            .main_delay_g         (main_path_delay[i]),
            .slow_delay_g         (slow_path_delay[i]),
            .ph_high_g            (phase_high_level[i]),
            .n_high_g             (neutral_high_level[i]),
            .ph_low_g             (phase_low_level[i]),
            .sel                  (cfg[i])
        );

        // Current source and scheme selection; neutral is only meaningful for three-pole tripping.
        assign src_ph[i]     = phase_current[cfg[i].measurement_source];
        assign src_n[i]      = neutral_current[cfg[i].measurement_source];
        assign three_pole[i] = (cfg[i].pole_mode == three_phase_scheme);
        assign blocked[i]    = !cfg[i].enable || scheme_inhibit[i];

        // Initiation stage: the single-pole scheme also accepts per-phase trip operands.
        assign trip_op[i] = three_phase_initiate[i] || (!three_pole[i] && (|phase_initiate[i]));
        assign cur_sup[i] = bfi_any_ge(src_ph[i], cfg[i].phase_supervision_level)
                            || (three_pole[i] && src_n[i] >= cfg[i].neutral_supervision_level);
        assign init_ok[i] = trip_op[i] && (!cfg[i].current_supervised_initiate_en || cur_sup[i]);
        // A held initiation only counts while current stays up, so a cleared fault drops it at once.
        assign active[i]  = !blocked[i] && (init_ok[i] || (s.inst[i].hold && cur_sup[i]));

        // Failure-determination stage only looks at timers once initiation is active.
        assign done_early[i] = active[i] && (s.inst[i].t_early >= cfg[i].early_path_delay);
        assign done_main[i]  = active[i] && (s.inst[i].t_main >= cfg[i].main_path_delay);
        assign done_slow[i]  = active[i] && (s.inst[i].t_slow >= cfg[i].slow_path_delay);

        // Hi-set applies at all times; lo-set joins once an early or main timeout has lasted the resistor interval.
        assign lo_run[i]    = done_early[i] || done_main[i];
        assign fault_cur[i] = bfi_any_ge(src_ph[i], cfg[i].phase_high_level)
                              || (three_pole[i] && src_n[i] >= cfg[i].neutral_high_level)
                              || (s.inst[i].t_loset >= `BFI_LOSET_DELAY
                                  && bfi_any_ge(src_ph[i], cfg[i].phase_low_level));

        // Outputs are registered so a glitch on a combinational term never reaches a trip coil.
        assign retrip[i]          = s.inst[i].retrip;
        assign early_path_fail[i] = s.inst[i].early_fail;
        assign main_path_fail[i]  = s.inst[i].main_fail;
        assign slow_path_fail[i]  = s.inst[i].slow_fail;
        assign zone_trip[i]       = s.inst[i].zone_trip;

        retrip_follow_a: assert property (active[i] |=> retrip[i])
            else $error("retrip did not follow initiation");
        inhibit_clear_a: assert property (blocked[i] |=> !retrip[i] && !zone_trip[i] && !s.inst[i].hold
                                          && s.inst[i].t_main == '0)
            else $error("blocked element left state or outputs set");
        supv_refuse_a: assert property (cfg[i].current_supervised_initiate_en && !cur_sup[i]
                                        && !s.inst[i].hold |=> !retrip[i])
            else $error("supervised initiation accepted without current");
        seal_drop_a: assert property (!cur_sup[i] |=> !s.inst[i].hold)
            else $error("seal-in held without current");
        early_aux_a: assert property (early_path_fail[i] |-> $past(aux_contact_early[i])
                                      && $past(done_early[i]))
            else $error("early path failed with breaker open or timer running");
        main_fault_a: assert property ($rose(main_path_fail[i]) |-> $past(fault_cur[i])
                                       && $past(done_main[i]))
            else $error("main path failed without fault current");
        slow_service_a: assert property (slow_path_fail[i] |-> !$past(out_of_service_flag[i])
                                         && $past(aux_contact_second[i]))
            else $error("slow path failed while out of service or breaker open");
        zero_delay_a: assert property (active[i] && cfg[i].main_path_en && cfg[i].main_path_delay == '0
                                       && fault_cur[i] |=> main_path_fail[i])
            else $error("zero main delay did not fail at once");
        group_default_a: assert property (active_group == `BFI_GROUP_NONE || active_group > `BFI_GROUP_LAST
                                          |-> cfg[i].enable == element_enable[i][0])
            else $error("no active group did not fall back to group one");
    end

    tick_spacing_a: assert property (s.tick |=> !s.tick)
        else $error("evaluation tick longer than one cycle");

    // Next state: millisecond divider, then per-element seal-in, timers and outputs.
    always_comb begin
        next_s = s;
        if (s.div == `BFI_DIV_W'(TICK_CYCLES - 1)) begin
            next_s.div  = '0;
            next_s.tick = 1'b1;
        end else begin
            next_s.div  = `BFI_DIV_W'(s.div + `BFI_DIV_ONE);
            next_s.tick = 1'b0;
        end
        for (int k = 0; k < `BFI_NUM_INST; k++) begin
            if (blocked[k]) begin
                next_s.inst[k] = '0;
            end else begin
                // Seal-in drops as soon as current falls, so a cleared fault never leaves it stuck.
                next_s.inst[k].hold    = cfg[k].hold_initiation_en && cur_sup[k] && active[k];
                next_s.inst[k].t_early = active[k] ? bfi_bump(s.inst[k].t_early, s.tick) : '0;
                next_s.inst[k].t_main  = active[k] ? bfi_bump(s.inst[k].t_main, s.tick) : '0;
                next_s.inst[k].t_slow  = active[k] ? bfi_bump(s.inst[k].t_slow, s.tick) : '0;
                next_s.inst[k].t_loset = lo_run[k] ? bfi_bump(s.inst[k].t_loset, s.tick) : '0;
                next_s.inst[k].retrip  = active[k];
                next_s.inst[k].early_fail = cfg[k].early_path_en && done_early[k]
                                            && aux_contact_early[k] && fault_cur[k];
                next_s.inst[k].main_fail  = cfg[k].main_path_en && done_main[k] && fault_cur[k];
                next_s.inst[k].slow_fail  = cfg[k].slow_path_en && done_slow[k]
                                            && aux_contact_second[k] && !out_of_service_flag[k];
                // Output stage: any failed path sets the zone trip.
                next_s.inst[k].zone_trip  = next_s.inst[k].early_fail || next_s.inst[k].main_fail
                                            || next_s.inst[k].slow_fail;
            end
        end
    end

    // State register; everything clears on reset.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

endmodule

`default_nettype wire

// ---- verif/bfi_far_side.sv ----
// Far-side model: protection trip source, breaker auxiliary contacts and a sequence timer.
// Assumes the bench drives its commands shortly after the rising edge of mclk.
`default_nettype none

module bfi_far_side #(
    parameter int SEQ_LIMIT = 30
) (
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic trip_cmd,
    input  wire logic breaker_open,
    output logic      trip_op,
    output logic      aux_early,
    output logic      aux_second,
    output logic      inhibit
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;

    // The protection logic issues the trip that starts the scheme.
    assign trip_op = trip_cmd;
    // Both contacts read closed until the breaker has opened mechanically.
    assign aux_early  = ~breaker_open;
    assign aux_second = ~breaker_open;
    // Set longer than every failure timer, so it only cuts a scheme that is left hanging.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt <= 0;
        end else if (!trip_op) begin
            cnt <= 0;
        end else if (cnt != SEQ_LIMIT) begin
            cnt <= cnt + 1;
        end
    end
    assign inhibit = (cnt == SEQ_LIMIT);
endmodule

`default_nettype wire

// ---- verif/tb_top.sv ----
// Bench for the two-element breaker-failure block, with a short tick and settings as plain arrays.
// Assumes bfi_pkg, bfi_defines.svh and the far-side model are compiled first.
`default_nettype none
`include "bfi_defines.svh"

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import bfi_pkg::*;
    localparam int TICK = 4;
    logic                  mclk = 1'b0;
    logic                  rst = 1'b1;
    logic                  trip_cmd = 1'b0;
    logic                  breaker_open = 1'b0;
    logic                  out_of_service = 1'b0;
    logic [2:0]            active_group = 3'h1;
    logic [1:0][5:0]       element_enable, current_supervised_initiate_en, hold_initiation_en;
    logic [1:0][5:0]       early_path_en, main_path_en, slow_path_en;
    bfi_pole_t [1:0][5:0]  pole_mode;
    logic [1:0][5:0][1:0]  measurement_source;
    bfi_level_t [1:0][5:0] phase_supervision_level, neutral_supervision_level;
    bfi_level_t [1:0][5:0] phase_high_level, neutral_high_level, phase_low_level;
    bfi_delay_t [1:0][5:0] early_path_delay, main_path_delay, slow_path_delay;
    bfi_level_t [3:0][2:0] phase_current;
    bfi_level_t [3:0]      neutral_current;
    logic [1:0][2:0]       phase_initiate;
    wire logic             p_trip, p_aux1, p_aux2, p_inh;
    wire logic [1:0]       three_phase_initiate, scheme_inhibit, aux_contact_early, aux_contact_second;
    wire logic [1:0]       out_of_service_flag, retrip, early_path_fail, main_path_fail, slow_path_fail, zone_trip;
    int                    n_mismatch = 0;
    int                    compares = 0;
    int                    cycles = 0;

    // The second element sees no trip, so any output there is cross-talk.
    assign three_phase_initiate = {1'b0, p_trip};
    assign scheme_inhibit       = {1'b0, p_inh};
    assign aux_contact_early    = {1'b1, p_aux1};
    assign aux_contact_second   = {1'b1, p_aux2};
    assign out_of_service_flag  = {1'b0, out_of_service};

    bfi_top #(.TICK_CYCLES(TICK)) uut (
        .mclk, .rst, .active_group, .element_enable, .pole_mode, .measurement_source,
        .current_supervised_initiate_en, .hold_initiation_en, .phase_supervision_level,
        .neutral_supervision_level, .early_path_en, .main_path_en, .slow_path_en, .early_path_delay,
        .main_path_delay, .slow_path_delay, .phase_high_level, .neutral_high_level, .phase_low_level,
        .phase_current, .neutral_current, .three_phase_initiate, .phase_initiate, .scheme_inhibit,
        .aux_contact_early, .aux_contact_second, .out_of_service_flag, .retrip, .early_path_fail,
        .main_path_fail, .slow_path_fail, .zone_trip
    );
    bfi_far_side #(.SEQ_LIMIT(30)) far (.mclk, .rst, .trip_cmd, .breaker_open, .trip_op(p_trip),
        .aux_early(p_aux1), .aux_second(p_aux2), .inhibit(p_inh));

    // Free-running 40 MHz clock.
    always #12.5 mclk = ~mclk;

    // A hang is cut short at 2000 cycles, well beyond the 84 cycles the tests need.
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 2000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    // Waits n edges and lands just after the last one, where outputs have settled.
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    // Compares both elements at once; the second must stay quiet throughout.
    task automatic chk(input logic [4:0] exp0);
        logic [9:0] got;
        got = {retrip[0], early_path_fail[0], main_path_fail[0], slow_path_fail[0], zone_trip[0],
               retrip[1], early_path_fail[1], main_path_fail[1], slow_path_fail[1], zone_trip[1]};
        compares++;
        if (got !== {exp0, 5'h00}) begin
            n_mismatch++;
            $display("MISMATCH t=%0t outputs %b expected %b", $time, got, {exp0, 5'h00});
        end
    endtask

    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Main sequence: defaults first, then each test changes only what it needs.
    initial begin
        {early_path_en, main_path_en, slow_path_en, element_enable} = '1;
        {current_supervised_initiate_en, hold_initiation_en, measurement_source, phase_initiate} = '0;
        {early_path_delay, main_path_delay, slow_path_delay, neutral_current} = '0;
        {phase_supervision_level, neutral_supervision_level, phase_high_level, neutral_high_level,
         phase_low_level} = {60{15'h041A}};
        foreach (pole_mode[i, j]) pole_mode[i][j] = three_phase_scheme;
        phase_current = {12{15'h07D0}};
        cyc(6);
        rst = 1'b0;
        trip_cmd = 1'b1;
        cyc(1);
        chk(5'h1F);
        breaker_open = 1'b1;
        cyc(1);
        chk(5'h15);
        phase_current = '0;
        cyc(1);
        chk(5'h10);
        neutral_current = {4{15'h07D0}};
        cyc(1);
        chk(5'h15);
        {trip_cmd, breaker_open} = 2'b00;
        neutral_current = '0;
        phase_current = {12{15'h0419}};
        cyc(1);
        chk(5'h00);
        $display("test direct done");
        current_supervised_initiate_en[0][0] = 1'b1;
        trip_cmd = 1'b1;
        cyc(2);
        chk(5'h00);
        phase_current = {12{15'h041A}};
        cyc(1);
        chk(5'h1F);
        trip_cmd = 1'b0;
        current_supervised_initiate_en[0][0] = 1'b0;
        phase_current = {12{15'h07D0}};
        cyc(1);
        $display("test supervised done");
        hold_initiation_en[0][0] = 1'b1;
        trip_cmd = 1'b1;
        cyc(1);
        trip_cmd = 1'b0;
        cyc(3);
        chk(5'h1F);
        phase_current = '0;
        cyc(1);
        chk(5'h00);
        hold_initiation_en[0][0] = 1'b0;
        phase_current = {12{15'h07D0}};
        $display("test seal-in done");
        element_enable[0][2] = 1'b0;
        active_group = 3'h3;
        trip_cmd = 1'b1;
        cyc(2);
        chk(5'h00);
        active_group = 3'h7;
        cyc(1);
        chk(5'h1F);
        trip_cmd = 1'b0;
        active_group = 3'h1;
        cyc(1);
        $display("test groups done");
        {early_path_en[0][0], main_path_en[0][0]} = 2'b00;
        slow_path_delay[0][0] = 16'h0003;
        trip_cmd = 1'b1;
        cyc(20);
        chk(5'h13);
        out_of_service = 1'b1;
        cyc(1);
        chk(5'h10);
        out_of_service = 1'b0;
        cyc(19);
        chk(5'h00);
        trip_cmd = 1'b0;
        {early_path_en[0][0], slow_path_en[0][0]} = 2'b10;
        cyc(2);
        $display("test inhibit done");
        early_path_delay[0][0] = 16'h0003;
        pole_mode[0][0] = single_phase_scheme;
        measurement_source[0][0] = 2'h2;
        phase_current = '0;
        phase_current[2][1] = 15'h07D0;
        phase_initiate[0][1] = 1'b1;
        cyc(8);
        chk(5'h10);
        cyc(10);
        chk(5'h19);
        $display("test delay done");
        tally_and_finish();
    end
endmodule

`default_nettype wire
